/* File: common/crf_defines.svh */
// Contract
// - Rx buffer n update sets its fresh-data flag, n from 0 to 31.
// - Fresh flags stay set until software writes one; zero is ignored.
// - Reset clears every fresh-data flag.
// - Read-only Tx done bit sets as its pending bit clears on success.
// - Writing one to a Tx add-request bit clears that buffer's done bit.
// - Walk enabled elements in order; stop at first match or list end.
// - Config 4 to 6 match sets priority flag and status; irq if enabled.
// - Config 0 disabled, 1 store FIFO 0, 2 store FIFO 1, 3 reject.
// - Config 4 priority, 5 priority and FIFO 0, 6 priority and FIFO 1.
// - Config 7 stores into a dedicated buffer; filter type is ignored.
// - Element word 0: bits 31:29 config, bits 28:0 first identifier.
// - Dedicated-buffer match is exact equality after the global mask.
// - Element word 1: bits 31:30 type, bits 28:0 second identifier.
// - Type 0 accepts masked identifier within first..second inclusive.
// - Type 1 accepts identifier equal to first or second identifier.
// - Type 2: first identifier is the value, second the bit mask.
// - Type 3 is a range filter without the global mask.
`ifndef CRF_DEFINES_SVH
`define CRF_DEFINES_SVH
`define CRF_OFF_NEW_DATA 12'h09c
`define CRF_OFF_TX_CANCEL 12'h0dc
`define CRF_OFF_TX_DONE 12'h0e0
`define CRF_OFF_TX_ADD 12'h0e4
`define CRF_OFF_TX_PEND 12'h0e8
`define CRF_OFF_GMASK 12'h040
`define CRF_OFF_INT_STS 12'h050
`define CRF_OFF_INT_MASK 12'h054
`define CRF_OFF_PRIO_STS 12'h058
`define CRF_OFF_FILT_BASE 12'h100
`define CRF_RST_WORD 32'h00000000
`define CRF_RST_GMASK 29'h1fffffff
`define CRF_INT_PRIO 0
`define CRF_INT_RXNEW 1
`define CRF_INT_TXDONE 2
`define CRF_CFG_MSB 31
`define CRF_CFG_LSB 29
`define CRF_TYPE_MSB 31
`define CRF_TYPE_LSB 30
`define CRF_ID_MSB 28
`define CRF_RESP_OKAY 2'b00
`define CRF_RESP_SLVERR 2'b10
`endif

/* File: common/crf_pkg.sv */
package crf_pkg;
    typedef struct packed {
        logic awvalid;
        logic [11:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [11:0] araddr;
        logic rready;
    } crf_axi_req_t;
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } crf_axi_rsp_t;
    typedef enum logic [2:0] {
        CFG_DISABLE, CFG_STORE_FIFO_ZERO, CFG_STORE_FIFO_ONE, CFG_REJECT,
        CFG_PRIORITY, CFG_PRIORITY_AND_FIFO_ZERO, CFG_PRIORITY_AND_FIFO_ONE,
        CFG_STORE_DEDICATED_BUFFER
    } crf_cfg_t;
    typedef enum logic [1:0] {
        TYPE_RANGE_WITH_MASK, TYPE_DUAL, TYPE_CLASSIC, TYPE_RANGE_NO_MASK
    } crf_type_t;
    typedef enum logic [1:0] {
        TGT_NONE, TGT_FIFO_ZERO, TGT_FIFO_ONE, TGT_DEDICATED
    } crf_tgt_t;
    typedef struct packed {
        logic valid;
        logic accept;
        crf_tgt_t target;
        logic prio;
        logic [7:0] index;
    } crf_res_t;
endpackage

/* File: rtl/crf_top.sv */
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "crf_defines.svh"
module crf_top #(
    parameter int NUM_FILT = 8
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Register bus.
    input wire crf_pkg::crf_axi_req_t axi_req,
    output var crf_pkg::crf_axi_rsp_t axi_rsp,
    // Receive side events.
    input wire logic rx_buf_upd,
    input wire logic [4:0] rx_buf_idx,
    input wire logic rx_id_valid,
    input wire logic [28:0] rx_id,
    output var crf_pkg::crf_res_t flt_res,
    output var logic flt_busy,
    // Transmit side events.
    input wire logic tx_success,
    input wire logic [4:0] tx_success_idx,
    input wire logic tx_cancel_done,
    input wire logic [4:0] tx_cancel_idx,
    output var logic [31:0] tx_pending_bit,
    // Interrupt.
    output var logic irq
);
    import crf_pkg::*;

    localparam int IW = $clog2(NUM_FILT);

    typedef enum logic {FLT_IDLE, FLT_SCAN} crf_fsm_t;

    typedef struct packed {
        logic aw_have;
        logic [11:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        crf_axi_rsp_t rsp;
        logic [31:0] new_data;
        logic [31:0] tx_done;
        logic [31:0] tx_pend;
        logic [31:0] tx_cancel;
        logic [28:0] gmask;
        logic [2:0] int_sts;
        logic [2:0] int_mask;
        logic [31:0] prio_sts;
        logic irq;
        crf_fsm_t fsm;
        logic busy;
        logic [IW-1:0] idx;
        logic [28:0] id;
        crf_res_t res;
    } crf_state_t;

    crf_state_t st_ff;
    crf_state_t nxt_st;
    logic [63:0] filt_mem [NUM_FILT];
    logic mem_we;
    logic [IW-1:0] mem_wsel;
    logic mem_whi;
    logic [31:0] mem_wdata;

    // -----------------------------------------------------------------
    // Filter evaluation
    // -----------------------------------------------------------------
    function automatic logic elem_match(input logic [63:0] e,
                                        input logic [28:0] id,
                                        input logic [28:0] gm);
        logic [28:0] id1;
        logic [28:0] id2;
        logic [28:0] mid;
        logic hit;
        id1 = e[`CRF_ID_MSB:0];
        id2 = e[32+`CRF_ID_MSB:32];
        mid = id & gm;
        hit = 1'b0;
        if (crf_cfg_t'(e[`CRF_CFG_MSB:`CRF_CFG_LSB]) ==
                CFG_STORE_DEDICATED_BUFFER) begin
            hit = (mid == id1);
        end else begin
            unique case (crf_type_t'(e[32+`CRF_TYPE_MSB:32+`CRF_TYPE_LSB]))
                TYPE_RANGE_WITH_MASK: hit = (mid >= id1) && (mid <= id2);
                TYPE_DUAL: hit = (mid == id1) || (mid == id2);
                TYPE_CLASSIC: hit = ((mid & id2) == (id1 & id2));
                TYPE_RANGE_NO_MASK: hit = (id >= id1) && (id <= id2);
            endcase
        end
        return hit;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // -----------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------
    logic [63:0] cur_elem;
    crf_cfg_t cur_cfg;
    logic wr_fire;
    logic [31:0] wmask;
    logic [31:0] rd_word;
    logic rd_ok;
    logic wr_ok;
    logic [31:0] nd_set;
    logic [31:0] to_set;
    logic [31:0] cf_set;
    logic [31:0] add_req;
    logic hpm_evt;
    logic [11:0] foff;

    assign cur_elem = filt_mem[st_ff.idx];
    assign cur_cfg = crf_cfg_t'(cur_elem[`CRF_CFG_MSB:`CRF_CFG_LSB]);

    always_comb begin
        nxt_st = st_ff;
        wr_fire = st_ff.aw_have && st_ff.w_have && !st_ff.rsp.bvalid;
        wmask = merge(32'h00000000, st_ff.w_data, st_ff.w_strb);
        foff = st_ff.aw_addr - `CRF_OFF_FILT_BASE;
        mem_we = 1'b0;
        mem_wsel = foff[IW+2:3];
        mem_whi = foff[2];
        mem_wdata = 32'h00000000;
        nd_set = 32'h00000000;
        to_set = 32'h00000000;
        cf_set = 32'h00000000;
        add_req = 32'h00000000;
        hpm_evt = 1'b0;
        wr_ok = 1'b1;
        nxt_st.res.valid = 1'b0;
        // Write channel: address and data are taken in either order.
        if (axi_req.awvalid && st_ff.rsp.awready) begin
            nxt_st.aw_have = 1'b1;
            nxt_st.aw_addr = axi_req.awaddr;
            nxt_st.rsp.awready = 1'b0;
        end
        if (axi_req.wvalid && st_ff.rsp.wready) begin
            nxt_st.w_have = 1'b1;
            nxt_st.w_data = axi_req.wdata;
            nxt_st.w_strb = axi_req.wstrb;
            nxt_st.rsp.wready = 1'b0;
        end
        if (wr_fire) begin
            nxt_st.aw_have = 1'b0;
            nxt_st.w_have = 1'b0;
            nxt_st.rsp.bvalid = 1'b1;
            unique case (st_ff.aw_addr[11:2])
                `CRF_OFF_NEW_DATA >> 2: ;
                `CRF_OFF_TX_ADD >> 2: add_req = wmask;
                `CRF_OFF_GMASK >> 2:
                    nxt_st.gmask = 29'(merge({3'b000, st_ff.gmask},
                        st_ff.w_data, st_ff.w_strb));
                `CRF_OFF_INT_STS >> 2: ;
                `CRF_OFF_INT_MASK >> 2: nxt_st.int_mask = wmask[2:0];
                default: begin
                    if (st_ff.aw_addr >= `CRF_OFF_FILT_BASE &&
                            foff < 12'(NUM_FILT * 8)) begin
                        mem_we = 1'b1;
                        mem_wdata = merge(filt_mem[mem_wsel][mem_whi*32 +: 32],
                            st_ff.w_data, st_ff.w_strb);
                    end else begin
                        wr_ok = 1'b0;
                    end
                end
            endcase
            nxt_st.rsp.bresp = wr_ok ? `CRF_RESP_OKAY : `CRF_RESP_SLVERR;
        end
        if (st_ff.rsp.bvalid && axi_req.bready) begin
            nxt_st.rsp.bvalid = 1'b0;
            nxt_st.rsp.awready = 1'b1;
            nxt_st.rsp.wready = 1'b1;
        end
        // Read channel: one-cycle answer after the address is taken.
        rd_ok = 1'b1;
        foff = axi_req.araddr - `CRF_OFF_FILT_BASE;
        unique case (axi_req.araddr[11:2])
            `CRF_OFF_NEW_DATA >> 2: rd_word = st_ff.new_data;
            `CRF_OFF_TX_CANCEL >> 2: rd_word = st_ff.tx_cancel;
            `CRF_OFF_TX_DONE >> 2: rd_word = st_ff.tx_done;
            `CRF_OFF_TX_ADD >> 2: rd_word = 32'h00000000;
            `CRF_OFF_TX_PEND >> 2: rd_word = st_ff.tx_pend;
            `CRF_OFF_GMASK >> 2: rd_word = {3'b000, st_ff.gmask};
            `CRF_OFF_INT_STS >> 2: rd_word = {29'h0, st_ff.int_sts};
            `CRF_OFF_INT_MASK >> 2: rd_word = {29'h0, st_ff.int_mask};
            `CRF_OFF_PRIO_STS >> 2: rd_word = st_ff.prio_sts;
            default: begin
                rd_word = 32'h00000000;
                if (axi_req.araddr >= `CRF_OFF_FILT_BASE &&
                        foff < 12'(NUM_FILT * 8)) begin
                    rd_word = filt_mem[foff[IW+2:3]][foff[2]*32 +: 32];
                end else begin
                    rd_ok = 1'b0;
                end
            end
        endcase
        if (axi_req.arvalid && st_ff.rsp.arready) begin
            nxt_st.rsp.arready = 1'b0;
            nxt_st.rsp.rvalid = 1'b1;
            nxt_st.rsp.rdata = rd_word;
            nxt_st.rsp.rresp = rd_ok ? `CRF_RESP_OKAY : `CRF_RESP_SLVERR;
        end
        if (st_ff.rsp.rvalid && axi_req.rready) begin
            nxt_st.rsp.rvalid = 1'b0;
            nxt_st.rsp.arready = 1'b1;
        end
        // Acceptance filter walk, one element per clock.
        unique case (st_ff.fsm)
            FLT_IDLE: begin
                if (rx_id_valid) begin
                    nxt_st.fsm = FLT_SCAN;
                    nxt_st.idx = '0;
                    nxt_st.id = rx_id;
                end
            end
            FLT_SCAN: begin
                if (cur_cfg != CFG_DISABLE &&
                        elem_match(cur_elem, st_ff.id, st_ff.gmask)) begin
                    nxt_st.fsm = FLT_IDLE;
                    nxt_st.res.valid = 1'b1;
                    nxt_st.res.index = 8'(st_ff.idx);
                    nxt_st.res.prio = 1'b0;
                    nxt_st.res.accept = 1'b1;
                    unique case (cur_cfg)
                        CFG_STORE_FIFO_ZERO: nxt_st.res.target = TGT_FIFO_ZERO;
                        CFG_STORE_FIFO_ONE: nxt_st.res.target = TGT_FIFO_ONE;
                        CFG_REJECT: begin
                            nxt_st.res.target = TGT_NONE;
                            nxt_st.res.accept = 1'b0;
                        end
                        CFG_PRIORITY: begin
                            nxt_st.res.target = TGT_NONE;
                            nxt_st.res.accept = 1'b0;
                        end
                        CFG_PRIORITY_AND_FIFO_ZERO:
                            nxt_st.res.target = TGT_FIFO_ZERO;
                        CFG_PRIORITY_AND_FIFO_ONE:
                            nxt_st.res.target = TGT_FIFO_ONE;
                        default: nxt_st.res.target = TGT_DEDICATED;
                    endcase
                    if (cur_cfg inside {CFG_PRIORITY, CFG_PRIORITY_AND_FIFO_ZERO,
                            CFG_PRIORITY_AND_FIFO_ONE}) begin
                        hpm_evt = 1'b1;
                        nxt_st.res.prio = 1'b1;
                        nxt_st.prio_sts = {1'b1, 20'h0, cur_cfg,
                            8'(st_ff.idx)};
                    end
                end else if (st_ff.idx == IW'(NUM_FILT - 1)) begin
                    // An identifier that hits nothing is dropped.
                    nxt_st.fsm = FLT_IDLE;
                    nxt_st.res = '{valid: 1'b1, accept: 1'b0,
                        target: TGT_NONE, prio: 1'b0, index: 8'h00};
                end else begin
                    nxt_st.idx = st_ff.idx + 1'b1;
                end
            end
        endcase
        // Flags: a hardware set in the same cycle as a software clear wins.
        if (rx_buf_upd) begin
            nd_set[rx_buf_idx] = 1'b1;
        end
        if (tx_success) begin
            to_set[tx_success_idx] = 1'b1;
        end
        if (tx_cancel_done) begin
            cf_set[tx_cancel_idx] = 1'b1;
        end
        nxt_st.new_data = (st_ff.new_data & ~((wr_fire &&
            st_ff.aw_addr == `CRF_OFF_NEW_DATA) ? wmask : 32'h0)) | nd_set;
        nxt_st.tx_done = (st_ff.tx_done & ~add_req) | to_set;
        nxt_st.tx_pend = (st_ff.tx_pend & ~to_set & ~cf_set) | add_req;
        nxt_st.tx_cancel = (st_ff.tx_cancel & ~add_req) | cf_set;
        nxt_st.int_sts = (st_ff.int_sts & ~((wr_fire &&
            st_ff.aw_addr == `CRF_OFF_INT_STS) ? wmask[2:0] : 3'h0)) |
            {|to_set, |nd_set, hpm_evt};
        nxt_st.irq = |(nxt_st.int_sts & nxt_st.int_mask);
        // Busy has its own flop so the pin comes straight from a register.
        nxt_st.busy = (nxt_st.fsm == FLT_SCAN);
    end

    // -----------------------------------------------------------------
    // State registers
    // -----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '0;
            st_ff.rsp.awready <= 1'b1;
            st_ff.rsp.wready <= 1'b1;
            st_ff.rsp.arready <= 1'b1;
            st_ff.gmask <= `CRF_RST_GMASK;
            st_ff.fsm <= FLT_IDLE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Filter elements sit in plain storage that reset leaves alone, as RAM.
    always_ff @(posedge clk) begin
        if (mem_we) begin
            filt_mem[mem_wsel][mem_whi*32 +: 32] <= mem_wdata;
        end
    end

    assign axi_rsp = st_ff.rsp;
    assign flt_res = st_ff.res;
    assign flt_busy = st_ff.busy;
    assign tx_pending_bit = st_ff.tx_pend;
    assign irq = st_ff.irq;

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_nd_set_flag: assert property (rx_buf_upd |=>
        st_ff.new_data[$past(rx_buf_idx)])
        else $error("fresh flag not set");
    a_nd_sticky: assert property ($fell(st_ff.new_data[0]) |->
        $past(wr_fire && st_ff.aw_addr == `CRF_OFF_NEW_DATA && wmask[0]))
        else $error("fresh flag dropped without clear");
    a_nd_reset: assert property ($past(rst) |->
        st_ff.new_data == 32'h0)
        else $error("fresh flags not cleared by reset");
    a_to_set_done: assert property (tx_success |=>
        st_ff.tx_done[$past(tx_success_idx)])
        else $error("done bit not set");
    a_tx_pend_drop: assert property (tx_success |=>
        !st_ff.tx_pend[$past(tx_success_idx)] ||
        $past(add_req[tx_success_idx]))
        else $error("pending bit not cleared");
    a_to_clear_add: assert property (
        (add_req & ~to_set) != 32'h0 |=>
        (st_ff.tx_done & $past(add_req & ~to_set)) == 32'h0)
        else $error("done bit not cleared");
    a_flt_walk_bound: assert property ($rose(flt_busy) |->
        ##[1:64] !flt_busy)
        else $error("filter walk too long");
    a_flt_busy_end: assert property (flt_res.valid |->
        !flt_busy)
        else $error("busy still high with result");
    a_flt_hpm_flag: assert property (
        flt_res.valid && flt_res.prio |->
        st_ff.int_sts[`CRF_INT_PRIO] && st_ff.prio_sts[31])
        else $error("priority match not flagged");
    a_flt_reject: assert property (
        flt_res.valid && flt_res.target == TGT_NONE |-> !flt_res.accept)
        else $error("reject accepted");
    a_irq_level: assert property (irq == |(st_ff.int_sts & st_ff.int_mask))
        else $error("interrupt level wrong");

    c_write_done: cover property (st_ff.rsp.bvalid && axi_req.bready);
    c_flt_prio: cover property (flt_res.valid && flt_res.prio);
    c_flt_dedicated: cover property (flt_res.valid &&
        flt_res.target == TGT_DEDICATED);
    c_nd_race: cover property (rx_buf_upd && wr_fire);
    c_tx_done: cover property (tx_success);
endmodule
`default_nettype wire

/* File: tb/crf_can_node.sv */
`timescale 1ns/1ns
`default_nettype none
module crf_can_node (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Filter handshake.
    input wire logic flt_busy,
    // Frame and transmit events.
    output var logic rx_buf_upd,
    output var logic [4:0] rx_buf_idx,
    output var logic rx_id_valid,
    output var logic [28:0] rx_id,
    output var logic tx_success,
    output var logic [4:0] tx_success_idx,
    output var logic tx_cancel_done,
    output var logic [4:0] tx_cancel_idx
);
    initial begin
        rx_buf_upd = 1'b0;
        rx_id_valid = 1'b0;
        tx_success = 1'b0;
        tx_cancel_done = 1'b0;
        rx_buf_idx = 5'h0a;
        tx_success_idx = 5'h15;
        tx_cancel_idx = 5'h0a;
        rx_id = 29'h0aaaaaaa;
    end

    // Kind 0 is a buffer update, 1 a sent frame, 2 a finished cancel.
    task automatic ev(input int kind, input logic [4:0] idx);
        @(posedge clk);
        rx_buf_upd <= (kind == 0);
        tx_success <= (kind == 1);
        tx_cancel_done <= (kind == 2);
        rx_buf_idx <= idx;
        tx_success_idx <= idx;
        tx_cancel_idx <= idx;
        @(posedge clk);
        rx_buf_upd <= 1'b0;
        tx_success <= 1'b0;
        tx_cancel_done <= 1'b0;
        // Stale index lines flip so a late sample cannot look valid.
        rx_buf_idx <= ~idx;
        tx_success_idx <= ~idx;
        tx_cancel_idx <= ~idx;
    endtask

    // A gap models a slow bus; an id is only offered while idle.
    task automatic send_id(input logic [28:0] id, input int gap,
                           output bit ok);
        ok = 1'b0;
        repeat (gap) @(posedge clk);
        for (int n = 0; n < 64 && !ok; n++) begin
            @(posedge clk);
            ok = !flt_busy;
        end
        if (ok) begin
            rx_id_valid <= 1'b1;
            rx_id <= id;
            @(posedge clk);
            rx_id_valid <= 1'b0;
            rx_id <= ~id;
        end
    endtask
endmodule
`default_nettype wire

/* File: tb/crf_top_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module crf_top_tb;
    import crf_pkg::*;
    localparam int NF = 8;
    logic clk;
    logic rst;
    crf_axi_req_t axi_req;
    crf_axi_rsp_t axi_rsp;
    crf_res_t flt_res;
    logic flt_busy, rx_buf_upd, rx_id_valid, tx_success, tx_cancel_done;
    logic irq;
    logic [4:0] rx_buf_idx, tx_success_idx, tx_cancel_idx, r;
    logic [28:0] rx_id, gm, id;
    logic [31:0] tx_pending_bit, e;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    logic [12:0] fq[$];
    logic [12:0] f;
    int failures, checked;
    bit ok;
    logic [31:0] w0[NF] = '{32'h00000aaa, 32'h60000bbb, 32'h20000100,
        32'h42340000, 32'h80000555, 32'ha0001000, 32'hc0002222,
        32'he0004444};
    logic [31:0] w1[NF] = '{32'h40000aaa, 32'h40000bbc, 32'h000001ff,
        32'h9fff0000, 32'h40000777, 32'hc0001010, 32'h40003333,
        32'h80000000};
    logic [28:0] ids[NF] = '{29'haaa, 29'hbbc, 29'h150, 29'h2345678,
        29'h777, 29'h1008, 29'h3333, 29'h4444};

    crf_top #(.NUM_FILT(NF)) uut (.clk(clk), .rst(rst),
        .axi_req(axi_req), .axi_rsp(axi_rsp), .rx_buf_upd(rx_buf_upd),
        .rx_buf_idx(rx_buf_idx), .rx_id_valid(rx_id_valid), .rx_id(rx_id),
        .flt_res(flt_res), .flt_busy(flt_busy), .tx_success(tx_success),
        .tx_success_idx(tx_success_idx), .tx_cancel_done(tx_cancel_done),
        .tx_cancel_idx(tx_cancel_idx), .tx_pending_bit(tx_pending_bit),
        .irq(irq));
    crf_can_node node (.clk(clk), .rst(rst), .flt_busy(flt_busy),
        .rx_buf_upd(rx_buf_upd), .rx_buf_idx(rx_buf_idx),
        .rx_id_valid(rx_id_valid), .rx_id(rx_id), .tx_success(tx_success),
        .tx_success_idx(tx_success_idx), .tx_cancel_done(tx_cancel_done),
        .tx_cancel_idx(tx_cancel_idx));

    // ---------------------------------------------------------------
    // Checking and closing.
    // ---------------------------------------------------------------
    task automatic check(input string what, input logic [33:0] seen,
                         input logic [33:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        if (failures == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic stall();
        failures++;
        summarize();
    endtask

    // ---------------------------------------------------------------
    // Register bus master.
    // ---------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] resp);
        bq.push_back(resp);
        @(posedge clk);
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr <= a;
        axi_req.wvalid <= 1'b1;
        axi_req.wdata <= d;
        axi_req.bready <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            @(posedge clk);
            if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
            if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
            if (axi_rsp.bvalid) begin
                axi_req.bready <= 1'b0;
                return;
            end
        end
        stall();
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] d,
                      input logic [1:0] resp);
        rq.push_back({resp, d});
        @(posedge clk);
        axi_req.arvalid <= 1'b1;
        axi_req.araddr <= a;
        axi_req.rready <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            @(posedge clk);
            if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
            if (axi_rsp.rvalid) begin
                axi_req.rready <= 1'b0;
                return;
            end
        end
        stall();
    endtask

    // ---------------------------------------------------------------
    // Filter reference: {match, accept, target, prio, index}.
    // ---------------------------------------------------------------
    function automatic logic [12:0] ref_flt(input logic [28:0] x);
        logic [28:0] m, a, b;
        logic [2:0] c;
        logic [1:0] t;
        logic hit;
        m = x & gm;
        for (int k = 0; k < NF; k++) begin
            c = w0[k][31:29];
            a = w0[k][28:0];
            b = w1[k][28:0];
            case (w1[k][31:30])
                2'd0: hit = m >= a && m <= b;
                2'd1: hit = m == a || m == b;
                2'd2: hit = (m & b) == (a & b);
                default: hit = x >= a && x <= b;
            endcase
            if (c == 3'd7) hit = (m == a);
            if (c != 3'd0 && hit) begin
                t = (c == 3'd7) ? 2'd3 : (c == 3'd1 || c == 3'd5) ? 2'd1 :
                    (c == 3'd2 || c == 3'd6) ? 2'd2 : 2'd0;
                return {1'b1, t != 2'd0, t, c[2] && c != 3'd7, 8'(k)};
            end
        end
        return 13'h0;
    endfunction

    task automatic fid(input logic [28:0] x, input int gap);
        fq.push_back(ref_flt(x));
        node.send_id(x, gap, ok);
        if (!ok) stall();
    endtask

    task automatic drain();
        for (int n = 0; n < 64; n++) begin
            if (fq.size() == 0) return;
            @(posedge clk);
        end
        stall();
    endtask

    // ---------------------------------------------------------------
    // Output watcher.
    // ---------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst) begin
            if (axi_rsp.rvalid && axi_req.rready) begin
                check("rdata", {axi_rsp.rresp, axi_rsp.rdata}, rq.pop_front());
            end
            if (axi_rsp.bvalid && axi_req.bready) begin
                check("bresp", axi_rsp.bresp, bq.pop_front());
            end
            if (flt_res.valid) begin
                f = fq.pop_front();
                if (f[12]) begin
                    check("flt", {1'b1, flt_res.accept, flt_res.target, flt_res.prio, flt_res.index}, f);
                end else begin
                    check("flt_none", {flt_res.accept, flt_res.target, flt_res.prio}, 4'h0);
                end
            end
        end
    end

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        repeat (100000) @(posedge clk);
        stall();
    end

    initial begin
        void'($urandom(23448));
        rst = 1'b1;
        axi_req = '0;
        axi_req.wstrb = 4'hf;
        gm = 29'h1fffffff;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(12'h09c, 32'h0, 2'b00);
        rd(12'h0dc, 32'h0, 2'b00);
        rd(12'h0e0, 32'h0, 2'b00);
        rd(12'h040, 32'h1fffffff, 2'b00);
        rd(12'h0fc, 32'h0, 2'b10);
        wr(12'h0fc, 32'hffffffff, 2'b10);
        r = 5'($urandom_range(30, 1));
        node.ev(0, 5'd0);
        node.ev(0, 5'd31);
        node.ev(0, r);
        e = 32'h80000001 | (32'h1 << r);
        rd(12'h09c, e, 2'b00);
        wr(12'h09c, 32'h0, 2'b00);
        rd(12'h09c, e, 2'b00);
        wr(12'h09c, 32'h1, 2'b00);
        rd(12'h09c, e & 32'hfffffffe, 2'b00);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(12'h09c, 32'h0, 2'b00);
        wr(12'h0e4, 32'h20, 2'b00);
        rd(12'h0e8, 32'h20, 2'b00);
        node.ev(1, 5'd5);
        node.ev(2, 5'd3);
        rd(12'h0e0, 32'h20, 2'b00);
        rd(12'h0dc, 32'h8, 2'b00);
        check("pend", tx_pending_bit, 32'h0);
        wr(12'h0e4, 32'h20, 2'b00);
        rd(12'h0e0, 32'h0, 2'b00);
        rd(12'h0e4, 32'h0, 2'b00);
        check("pend", tx_pending_bit, 32'h20);
        // Filter RAM has no reset, so every element is written first.
        for (int k = 0; k < NF; k++) begin
            wr(12'(12'h100 + 8 * k), w0[k], 2'b00);
            wr(12'(12'h104 + 8 * k), w1[k], 2'b00);
        end
        rd(12'h118, w0[3], 2'b00);
        rd(12'h11c, w1[3], 2'b00);
        rd(12'h050, 32'h4, 2'b00);
        wr(12'h050, 32'h7, 2'b00);
        fid(ids[4], 0);
        drain();
        rd(12'h050, 32'h1, 2'b00);
        rd(12'h058, 32'h80000404, 2'b00);
        check("irq", irq, 1'b0);
        wr(12'h054, 32'h1, 2'b00);
        repeat (3) @(posedge clk);
        check("irq", irq, 1'b1);
        wr(12'h050, 32'h1, 2'b00);
        repeat (3) @(posedge clk);
        check("irq", irq, 1'b0);
        for (int i = 0; i < NF; i++) fid(ids[i], i % 2);
        drain();
        gm = 29'h00000fff;
        wr(12'h040, 32'h00000fff, 2'b00);
        fid(29'h5150, 0);
        fid(29'h1008, 0);
        for (int i = 0; i < 24; i++) begin
            id = (i % 2) ? 29'($urandom) : ids[i % 8] | 29'($urandom) << 12;
            fid(id, int'($urandom_range(2, 0)));
        end
        drain();
        summarize();
    end
endmodule
`default_nettype wire
